//--- rtl/hbi_device.sv
// device end: decode, latch, lane steering, data fifos, ready logic
//
// How it works
// RQ1 - decode A15..A4 with address enable
// RQ2 - latch transparent in strobe, hold at rise
// RQ3 - all widths; dword write at C hits bank
// RQ4 - no byte swapping, no eight bit mode
// RQ5 - sixteen bit bus swaps words on A1
// RQ6 - async access acts on strobe edges
// RQ7 - ready drops on a strobe the fifo cannot meet, released by clock
// RQ8 - sync mode uses cycle strobe, sync ready
// RQ9 - host keeps bus clock in limits
// RQ10 - datapath select bypasses decode and bank
// RQ11 - datapath select accesses are 32 bit
// RQ12 - datapath select async or burst dma
// RQ13 - host never mixes sync and async
// RQ14 - arbiter orders host and mac requests
// RQ15 - memory reads 32 bit, lanes steered
// RQ16 - two fifos; not ready when unmet
// RQ17 - phy chip select in bank 7 low
// RQ18 - ready held off until grant
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module hbi_device
  import hbi_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        NRST_IN,
  hbi_if.device            bus,
  input  wire logic        MAC_REQ_IN,     // mac dma wants memory
  output logic             MAC_GNT_OUT,
  output logic             MEM_REQ_OUT,    // memory cycle start
  output logic             MEM_WR_OUT,
  output logic [31:0]      MEM_WDATA_OUT,
  input  wire logic [31:0] MEM_RDATA_IN,
  output logic [15:0]      BANK_SEL_OUT
);
  import hbi_pkg::*;

  // ---------------------------------------------------------------
  // address latch and decode
  // ---------------------------------------------------------------
  logic [15:0] addr_q;
  wire  latch_open = !bus.address_strobe_n && bus.read_strobe_n &&
                     bus.write_strobe_n;
  // latch open while strobe low and no data strobe
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      addr_q <= 16'h0000;
    end else begin
      if (latch_open) begin
        addr_q <= bus.addr; // RQ2
      end
    end
  end
  wire [15:0] addr_eff = latch_open ? bus.addr : addr_q;
  wire hit = bus.address_enable == 1'b0 &&
             addr_eff[15:4] == BASE_ADDR_HI; // RQ1
  wire dp_sel = !bus.datapath_select_n; // RQ10 RQ12
  wire [3:0] ofs = addr_eff[3:0];

  // ---------------------------------------------------------------
  // access detection
  // ---------------------------------------------------------------
  wire async_act = !bus.read_strobe_n || !bus.write_strobe_n; // RQ6
  wire sync_act  = !bus.local_bus_mode_n && !bus.cycle_strobe_n; // RQ8
  wire is_write  = sync_act ? bus.write_not_read : !bus.write_strobe_n;
  logic act_q;
  wire act = (async_act || sync_act) && (hit || dp_sel);
  wire act_start = act && !act_q;
  wire is_data = dp_sel || ofs[3:2] == OFS_DATA_REG[3:2]; // RQ10

  // ---------------------------------------------------------------
  // bank register
  // ---------------------------------------------------------------
  logic [15:0] bank;
  wire bank_dw  = ofs == OFS_BANK_DWORD && bus.byte_en_n == 4'h0; // RQ3
  wire bank_hit = !dp_sel && (ofs[3:1] == OFS_BANK_SEL[3:1] || bank_dw);
  // bank register write, dword at C lands only in the upper word
  wire [31:0] wdat = bus.bus16 ?
                     hbi_swap_words(bus.data_host, addr_eff[1]) :
                     bus.data_host; // RQ5 RQ4
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      bank <= BANK_SEL_RESET;
    end else if (act_start && is_write && bank_hit) begin
      if (!bus.byte_en_n[2]) bank[7:0]  <= wdat[23:16]; // RQ3
      if (!bus.byte_en_n[3]) bank[15:8] <= wdat[31:24];
    end
  end
  assign BANK_SEL_OUT = bank;

  // ---------------------------------------------------------------
  // fifos toward and from packet memory
  // ---------------------------------------------------------------
  logic [31:0] txf [FIFO_DEPTH];
  logic [31:0] rxf [FIFO_DEPTH];
  logic [PTR_W:0] tx_wp, tx_rp, rx_wp, rx_rp;
  wire tx_full  = (tx_wp - tx_rp) == (PTR_W+1)'(FIFO_DEPTH);
  wire tx_empty = tx_wp == tx_rp;
  wire rx_full  = (rx_wp - rx_rp) == (PTR_W+1)'(FIFO_DEPTH);
  wire rx_empty = rx_wp == rx_rp;
  // started cycle the fifo cannot meet holds not ready
  wire can_meet = is_data ? (is_write ? !tx_full : !rx_empty) : 1'b1;

  // arbiter: mac first when both request, host otherwise
  wire host_need = !tx_empty || !rx_full;
  wire gnt_mac   = MAC_REQ_IN; // RQ14
  wire gnt_host  = !MAC_REQ_IN && host_need;
  wire host_rd   = gnt_host && tx_empty;

  // ---------------------------------------------------------------
  // access state
  // ---------------------------------------------------------------
  hbi_state_t st, next_st;
  always_comb begin
    next_st = st;
    case (st)
      HBI_IDLE: begin
        if (act && can_meet) next_st = HBI_DONE; // RQ18
        else if (act) next_st = HBI_WAIT; // RQ16
      end
      HBI_WAIT: begin
        if (!act) next_st = HBI_IDLE;
        else if (can_meet) next_st = HBI_DONE;
      end
      HBI_DONE: begin
        if (!act) next_st = HBI_IDLE;
      end
      default: next_st = HBI_IDLE;
    endcase
  end
  wire take = (st != HBI_DONE) && next_st == HBI_DONE && is_data;

  // fifo pointers and storage
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      st    <= HBI_IDLE;
      act_q <= 1'b0;
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
    end else begin
      st    <= next_st;
      act_q <= act;
      if (take && is_write) begin
        txf[tx_wp[PTR_W-1:0]] <= wdat;
        tx_wp <= tx_wp + 1'b1;
      end
      if (take && !is_write) rx_rp <= rx_rp + 1'b1;
      if (gnt_host && !tx_empty) tx_rp <= tx_rp + 1'b1;
      if (host_rd && !rx_full) begin
        rxf[rx_wp[PTR_W-1:0]] <= MEM_RDATA_IN; // RQ15
        rx_wp <= rx_wp + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  wire [31:0] rd_raw = is_data ? rxf[rx_rp[PTR_W-1:0]] :
                       {bank, 16'h0000};
  wire [31:0] rd_lane = bus.bus16 ?
                        hbi_swap_words(rd_raw, addr_eff[1]) : rd_raw;
  wire phy_cs = hit && !dp_sel && ofs[3] == 1'b0 &&
                bank[2:0] == PHY_BANK; // RQ17
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      bus.data_dev            <= 32'h0000_0000;
      bus.data_dev_oe         <= 1'b0;
      bus.async_ready         <= 1'b1;
      bus.sync_ready_n        <= 1'b1;
      bus.phy_window_select_n <= 1'b1;
      MAC_GNT_OUT             <= 1'b0;
      MEM_REQ_OUT             <= 1'b0;
      MEM_WR_OUT              <= 1'b0;
      MEM_WDATA_OUT           <= 32'h0000_0000;
    end else begin
      bus.data_dev    <= rd_lane; // RQ15
      bus.data_dev_oe <= act && !is_write && !phy_cs;
      // ready low from strobe start only while the fifo cannot meet it, released by clock when met
      // an access that misses the decode leaves ready alone
      bus.async_ready <= !(async_act && act &&
                           next_st != HBI_DONE); // RQ7
      bus.sync_ready_n <= !(sync_act && next_st == HBI_DONE &&
                            st != HBI_DONE); // RQ8
      bus.phy_window_select_n <= !phy_cs; // RQ17
      MAC_GNT_OUT   <= gnt_mac; // RQ14
      MEM_REQ_OUT   <= gnt_host;
      MEM_WR_OUT    <= gnt_host && !tx_empty;
      MEM_WDATA_OUT <= txf[tx_rp[PTR_W-1:0]];
    end
  end
endmodule : hbi_device
`default_nettype wire

//--- pkg/hbi_pkg.sv
// shared constants and types for the host bus interface
package hbi_pkg;
  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [11:0] BASE_ADDR_HI    = 12'h030;  // A15..A4 match
  localparam logic [3:0]  OFS_BANK_SEL    = 4'hE;     // bank select word
  localparam logic [3:0]  OFS_BANK_DWORD  = 4'hC;     // dword write alias
  localparam logic [3:0]  OFS_DATA_REG    = 4'h8;     // data register
  localparam logic [2:0]  PHY_BANK        = 3'h7;     // external phy bank
  localparam logic [15:0] BANK_SEL_RESET  = 16'h3300;
  localparam int          FIFO_DEPTH      = 4;
  localparam int          PTR_W           = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int LB_MAX_MHZ     = 50;
  localparam int DMA_MAX_MHZ_X100 = 833;
  localparam int ACK_HOLD_CYC   = 1;
  // device access state
  typedef enum logic [1:0] {
    HBI_IDLE = 2'b00,
    HBI_WAIT = 2'b01,
    HBI_DONE = 2'b11
  } hbi_state_t;
  // byte lane steering by address, rotates a dword
  function automatic logic [31:0] hbi_swap_words(input logic [31:0] d,
                                                 input logic a1);
    hbi_swap_words = a1 ? {d[15:0], d[31:16]} : d;
  endfunction : hbi_swap_words
endpackage : hbi_pkg

//--- pkg/hbi_if.sv
// host bus pins between the host controller and the device end
`timescale 1ns/1ps
`default_nettype none
interface hbi_if;
  logic [15:0] addr;
  logic        address_enable;
  logic        address_strobe_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic        cycle_strobe_n;
  logic        write_not_read;
  logic        local_bus_mode_n;
  logic        datapath_select_n;
  logic [3:0]  byte_en_n;
  logic        bus16;
  logic [31:0] data_host;      // host drives
  logic        data_host_oe;
  logic [31:0] data_dev;       // device drives
  logic        data_dev_oe;
  logic        async_ready;
  logic        sync_ready_n;
  logic        phy_window_select_n;
  modport device (
    input  addr, address_enable, address_strobe_n, read_strobe_n,
           write_strobe_n, cycle_strobe_n, write_not_read,
           local_bus_mode_n, datapath_select_n, byte_en_n, bus16,
           data_host, data_host_oe,
    output data_dev, data_dev_oe, async_ready, sync_ready_n,
           phy_window_select_n
  );
  modport host (
    output addr, address_enable, address_strobe_n, read_strobe_n,
           write_strobe_n, cycle_strobe_n, write_not_read,
           local_bus_mode_n, datapath_select_n, byte_en_n, bus16,
           data_host, data_host_oe,
    input  data_dev, data_dev_oe, async_ready, sync_ready_n,
           phy_window_select_n
  );
endinterface : hbi_if
`default_nettype wire

//--- rtl/hbi_host.sv
// host end: ahb-lite command registers driving the host bus pins
`timescale 1ns/1ps
`default_nettype none
module hbi_host
  import hbi_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        NRST_IN,
  hbi_if.host              bus,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT
);
  import hbi_pkg::*;
  localparam logic [7:0] R_ADDR = 8'h00, R_DATA = 8'h04, R_CTRL = 8'h08,
                         R_STAT = 8'h0C;

  logic [31:0] a_reg, d_reg, rd_reg;
  logic [7:0]  ctrl; // 0 go, 1 write, 2 sync, 3 dp, 4 bus16, 7:5 unused
  logic        busy, done;
  logic        ph_wr, ph_v;
  logic [7:0]  ph_a;
  logic [1:0]  step;
  logic        armed;  // device has had one edge to see the strobe
  wire  start = ph_v && ph_wr && ph_a == R_CTRL && HWDATA_IN[0] && !busy;
  wire  rdy_seen = ctrl[2] ? !bus.sync_ready_n : bus.async_ready;

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      ph_v <= 1'b0;
      ph_wr <= 1'b0;
      ph_a <= 8'h00;
      a_reg <= 32'h0;
      d_reg <= 32'h0;
      ctrl <= 8'h00;
    end else begin
      ph_v  <= HSEL_IN && HTRANS_IN[1] && HREADY_IN;
      ph_wr <= HWRITE_IN;
      ph_a  <= HADDR_IN[7:0];
      if (ph_v && ph_wr && ph_a == R_ADDR) a_reg <= HWDATA_IN;
      if (ph_v && ph_wr && ph_a == R_DATA) d_reg <= HWDATA_IN;
      if (ph_v && ph_wr && ph_a == R_CTRL && !busy) ctrl <= HWDATA_IN[7:0];
    end
  end
  wire [31:0] rd_mux = ph_a == R_ADDR ? a_reg :
                       ph_a == R_DATA ? rd_reg :
                       ph_a == R_CTRL ? {24'h0, ctrl} :
                       ph_a == R_STAT ? {30'h0, done, busy} : 32'h0;
  assign HRDATA_OUT = rd_mux;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  // ---------------------------------------------------------------
  // bus cycle: address, strobe, wait for ready, release
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      busy <= 1'b0;
      done <= 1'b0;
      step <= 2'd0;
      armed <= 1'b0;
      rd_reg <= 32'h0;
      bus.addr <= 16'h0;
      bus.address_enable <= 1'b1;
      bus.address_strobe_n <= 1'b1;
      bus.read_strobe_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.cycle_strobe_n <= 1'b1;
      bus.write_not_read <= 1'b0;
      bus.local_bus_mode_n <= 1'b1;
      bus.datapath_select_n <= 1'b1;
      bus.byte_en_n <= 4'hF;
      bus.bus16 <= 1'b0;
      bus.data_host <= 32'h0;
      bus.data_host_oe <= 1'b0;
    end else begin
      if (ph_v && ph_wr && ph_a == R_CTRL) done <= 1'b0;
      case (step)
        2'd0: if (start) begin
          busy <= 1'b1;
          step <= 2'd1;
          bus.addr <= a_reg[15:0];
          bus.byte_en_n <= HWDATA_IN[3] ? 4'h0 : ~a_reg[19:16]; // RQ11
          bus.address_enable <= 1'b0;
          bus.address_strobe_n <= 1'b0;
          bus.local_bus_mode_n <= !HWDATA_IN[2];
          bus.datapath_select_n <= !HWDATA_IN[3]; // RQ12
          bus.bus16 <= HWDATA_IN[4];
          bus.write_not_read <= HWDATA_IN[1];
          bus.data_host <= d_reg;
          bus.data_host_oe <= HWDATA_IN[1];
        end
        2'd1: begin
          bus.address_strobe_n <= 1'b1;
          // only one kind of strobe is ever active
          if (ctrl[2]) bus.cycle_strobe_n <= 1'b0; // RQ13
          else if (ctrl[1]) bus.write_strobe_n <= 1'b0;
          else bus.read_strobe_n <= 1'b0;
          step <= 2'd2;
        end
        2'd2: if (!armed) begin
          // ready before the device saw the strobe is stale
          armed <= 1'b1;
        end else if (rdy_seen) begin // RQ7
          // cycle extended until ready returns
          armed <= 1'b0;
          rd_reg <= bus.data_dev;
          bus.read_strobe_n <= 1'b1;
          bus.write_strobe_n <= 1'b1;
          bus.cycle_strobe_n <= 1'b1;
          bus.data_host_oe <= 1'b0;
          bus.address_enable <= 1'b1;
          step <= 2'd3;
        end
        default: begin
          busy <= 1'b0;
          done <= 1'b1;
          step <= 2'd0;
        end
      endcase
    end
  end
endmodule : hbi_host
`default_nettype wire

//--- verification/hbi_monitor.sv
// checker on the host bus pins between host end and device end
`timescale 1ns/1ps
`default_nettype none
module hbi_monitor (
  input wire logic        CLK_SYS_IN,
  input wire logic        NRST_IN,
  input wire logic [15:0] addr,
  input wire logic        address_enable,
  input wire logic        address_strobe_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic        cycle_strobe_n,
  input wire logic        data_host_oe,
  input wire logic        data_dev_oe,
  input wire logic        async_ready,
  input wire logic        sync_ready_n,
  input wire logic        phy_window_select_n
);
  import hbi_pkg::*;
  // ----------------
  // bus properties
  // ----------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  // an asynchronous data strobe is active
  wire data_strobe = !read_strobe_n || !write_strobe_n;
  sequence s_ready_back;
    ##[1:200] async_ready;
  endsequence
  sequence s_one_low;
    !sync_ready_n ##1 sync_ready_n;
  endsequence
  property p_ready_release;
    $fell(async_ready) |-> s_ready_back;
  endproperty
  property p_host_waits;
    data_strobe && !async_ready |=> data_strobe;
  endproperty
  property p_sync_pulse;
    $fell(sync_ready_n) |-> s_one_low;
  endproperty
  property p_sync_in_cycle;
    !sync_ready_n |-> !cycle_strobe_n;
  endproperty
  property p_no_mix;
    !cycle_strobe_n |-> !data_strobe;
  endproperty
  property p_latch_closed;
    data_strobe |-> address_strobe_n;
  endproperty
  property p_ads_pulse;
    $fell(address_strobe_n) |=> address_strobe_n;
  endproperty
  property p_phy_window;
    data_strobe && !phy_window_select_n |->
      !address_enable && addr[15:4] == BASE_ADDR_HI && !addr[3];
  endproperty
  property p_oe_exclusive;
    data_host_oe |-> !data_dev_oe;
  endproperty
  a_ready_release: assert property (p_ready_release)
    else $error("async ready held low too long");
  a_host_waits: assert property (p_host_waits)
    else $error("strobe released before ready");
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync ready low longer than one cycle");
  a_sync_in_cycle: assert property (p_sync_in_cycle)
    else $error("sync ready outside a cycle strobe");
  a_no_mix: assert property (p_no_mix)
    else $error("sync and async cycles overlap");
  a_latch_closed: assert property (p_latch_closed)
    else $error("address strobe low during data strobe");
  a_ads_pulse: assert property (p_ads_pulse)
    else $error("address strobe longer than one cycle");
  a_phy_window: assert property (p_phy_window)
    else $error("phy select outside low window");
  a_oe_exclusive: assert property (p_oe_exclusive)
    else $error("both ends drive data");
endmodule : hbi_monitor
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hbi_pkg::*;
  // ---------------------
  // stimulus and wiring
  // ---------------------
  localparam logic [31:0] MEM_WORD = 32'h1357_9BDF;
  localparam logic [31:0] DP_WORD  = 32'hA5C3_0F96;
  logic        clk      = 1'h0;
  logic        rst_n    = 1'h0;
  logic        hsel     = 1'h0;
  logic        hwrite   = 1'h0;
  logic        mac_req  = 1'h0;
  logic        phy_seen = 1'h0;
  logic [1:0]  htrans   = 2'h0;
  logic [31:0] haddr    = 32'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] mem_w    = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] mem_wdata;
  logic [15:0] bank;
  logic        hready;
  logic        mem_req;
  logic        mem_wr;
  logic        mac_gnt;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  hbi_if bus ();
  hbi_host u_hbi_host (
    .CLK_SYS_IN(clk), .NRST_IN(rst_n), .bus(bus), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT()
  );
  hbi_device u_hbi_device (
    .CLK_SYS_IN(clk), .NRST_IN(rst_n), .bus(bus), .MAC_REQ_IN(mac_req),
    .MAC_GNT_OUT(mac_gnt), .MEM_REQ_OUT(mem_req), .MEM_WR_OUT(mem_wr),
    .MEM_WDATA_OUT(mem_wdata), .MEM_RDATA_IN(MEM_WORD),
    .BANK_SEL_OUT(bank)
  );
  hbi_monitor u_hbi_monitor (
    .CLK_SYS_IN(clk), .NRST_IN(rst_n), .addr(bus.addr),
    .address_enable(bus.address_enable),
    .address_strobe_n(bus.address_strobe_n),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .cycle_strobe_n(bus.cycle_strobe_n), .data_host_oe(bus.data_host_oe),
    .data_dev_oe(bus.data_dev_oe), .async_ready(bus.async_ready),
    .sync_ready_n(bus.sync_ready_n),
    .phy_window_select_n(bus.phy_window_select_n)
  );
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  // count cycles, watch phy select and memory writes, cut hangs short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bus.phy_window_select_n === 1'h0) phy_seen <= 1'h1;
    if (mem_req === 1'h1 && mem_wr === 1'h1) mem_w <= mem_wdata;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // ---------------
  // shared tasks
  // ---------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    r = hrdata;
  endtask : ahb
  task automatic hstart(input logic [4:0] ctl, input logic [3:0] be,
                        input logic [15:0] a, input logic [31:0] d);
    logic [31:0] s;
    ahb(1'h1, 8'h00, {12'h0, be, a}, s);
    ahb(1'h1, 8'h04, d, s);
    ahb(1'h1, 8'h08, {27'h0, ctl}, s);
  endtask : hstart
  task automatic hwait(output logic [31:0] r);
    logic [31:0] s;
    s = 32'h0;
    while (s[1] !== 1'h1) ahb(1'h0, 8'h0C, 32'h0, s);
    chk("status done", 32'h2, {30'h0, s[1:0]});
    ahb(1'h0, 8'h04, 32'h0, r);
  endtask : hwait
  task automatic hop(input logic [4:0] ctl, input logic [3:0] be,
                     input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hstart(ctl, be, a, d);
    hwait(r);
  endtask : hop
  // -----------
  // scenarios
  // -----------
  task automatic t_bank();
    logic [31:0] r;
    chk("bank reset", {16'h0, BANK_SEL_RESET}, {16'h0, bank});
    hop(5'h03, 4'hF, {BASE_ADDR_HI, OFS_BANK_DWORD}, 32'h0007_ABCD, r);
    chk("bank dword", 32'h7, {16'h0, bank});
    hop(5'h03, 4'hF, {12'h031, OFS_BANK_DWORD}, 32'h0002_0000, r);
    chk("bank miss", 32'h7, {16'h0, bank});
  endtask : t_bank
  task automatic t_phy();
    logic [31:0] r;
    phy_seen = 1'h0;
    hop(5'h01, 4'hF, {BASE_ADDR_HI, 4'h0}, 32'h0, r);
    chk("phy select bank 7", 32'h1, {31'h0, phy_seen});
    hop(5'h03, 4'hF, {BASE_ADDR_HI, OFS_BANK_DWORD}, 32'h0002_0000, r);
    phy_seen = 1'h0;
    hop(5'h01, 4'hF, {BASE_ADDR_HI, 4'h0}, 32'h0, r);
    chk("phy select bank 2", 32'h0, {31'h0, phy_seen});
  endtask : t_phy
  // datapath write off the map, then a read held off by the mac
  task automatic t_dp();
    logic [31:0] r;
    logic [31:0] s;
    hop(5'h0B, 4'hF, 16'h0000, DP_WORD, r);
    for (int n = 0; n < 50 && mem_w !== DP_WORD; n++) @(posedge clk);
    chk("datapath write", DP_WORD, mem_w);
    mac_req <= 1'h1;
    // drain the prefetched words so that the next read must wait
    for (int n = 0; n < FIFO_DEPTH; n++) begin
      hop(5'h09, 4'hF, 16'h0000, 32'h0, r);
      chk("prefetched read", MEM_WORD, r);
    end
    hstart(5'h09, 4'hF, 16'h0000, 32'h0);
    repeat (8) ahb(1'h0, 8'h0C, 32'h0, s);
    chk("busy under mac", 32'h1, {30'h0, s[1:0]});
    chk("mac grant", 32'h1, {31'h0, mac_gnt});
    mac_req <= 1'h0;
    hwait(r);
    chk("datapath read", MEM_WORD, r);
  endtask : t_dp
  task automatic t_lanes();
    logic [31:0] r;
    hop(5'h01, 4'h2, {BASE_ADDR_HI, 4'h9}, 32'h0, r);
    chk("byte lane 1", {24'h0, MEM_WORD[15:8]}, {24'h0, r[15:8]});
    hop(5'h11, 4'h3, {BASE_ADDR_HI, 4'hA}, 32'h0, r);
    chk("word swap", {16'h0, MEM_WORD[31:16]}, {16'h0, r[15:0]});
    hop(5'h05, 4'hF, {BASE_ADDR_HI, OFS_DATA_REG}, 32'h0, r);
    chk("sync data read", MEM_WORD, r);
  endtask : t_lanes
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // reset for two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_bank();
    t_phy();
    t_dp();
    t_lanes();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
